/* File: hw/cdral_acq_ctrl.v */
`timescale 1ns/1ps
`include "cdral_regs.vh"

module cdral_acq_ctrl #(
  parameter DCO_W  = 12,
  parameter DIV_W  = 4,
  parameter STEP_W = 4
) (
  input  wire             sys_clk_in,
  input  wire             nrst_in,
  input  wire             ce_in,
  input  wire [7:0]       reg_addr_in,
  input  wire [7:0]       reg_wdata_in,
  input  wire             reg_wr_in,
  input  wire             reg_rd_in,
  output reg  [7:0]       reg_rdata_out,
  input  wire [6:0]       factory_offset_in,
  input  wire             freq_valid_in,
  input  wire signed [15:0] freq_diff_ppm_in,
  input  wire             rate_fast_in,
  output reg              loss_of_lock_out,
  output reg              fll_en_out,
  output reg              pll_dll_en_out,
  output reg  [DCO_W-1:0] digital_oscillator_out,
  output reg  [DIV_W-1:0] div_exp_out,
  output reg              slice_en_out,
  output reg              slice_coarse_out,
  output reg  [6:0]       slice_level_out,
  output reg              adaptive_offset_en_out,
  output reg              edge_rise_only_out,
  output reg              edge_fall_only_out,
  output reg  [1:0]       dll_slew_out,
  output reg  [2:0]       dll_track_quarter_ui_out,
  output reg  [3:0]       sample_phase_out,
  output reg  [2:0]       jitter_transfer_bandwidth_out,
  output reg              loop_open_out
);

  // ----------------------------------------------------------------
  // State encoding
  // ----------------------------------------------------------------
  localparam [2:0] ST_START  = 3'h1;
  localparam [2:0] ST_SEARCH = 3'h2;
  localparam [2:0] ST_TRACK  = 3'h4;

  localparam [STEP_W-1:0] STEP_MAX = {STEP_W{1'b1}};
  localparam [DIV_W-1:0]  DIV_MAX  = {DIV_W{1'b1}};
  localparam [DCO_W-1:0]  DCO_TOP  = {DCO_W{1'b1}};

  // Magnitude of a signed ppm error, used by every window comparison.
  function [15:0] abs_ppm;
    input signed [15:0] v;
    begin
      abs_ppm = v[15] ? (~v + 16'h0001) : v;
    end
  endfunction

  // Oscillator increment for a step exponent, saturating at the top.
  // A step wider than the oscillator word would shift out to zero, so it
  // saturates as well; otherwise the first coarse steps would do nothing.
  function [DCO_W-1:0] dco_add;
    input [DCO_W-1:0]  cur;
    input [STEP_W-1:0] sexp;
    reg   [DCO_W:0]    sum;
    begin
      sum = {1'b0, cur} + ({{DCO_W{1'b0}}, 1'b1} << sexp);
      dco_add = (sum[DCO_W] || (sexp >= DCO_W)) ? DCO_TOP : sum[DCO_W-1:0];
    end
  endfunction

  // Oscillator back-off by one step; wraps rather than saturating at zero.
  function [DCO_W-1:0] dco_sub;
    input [DCO_W-1:0]  cur;
    input [STEP_W-1:0] sexp;
    reg   [DCO_W:0]    inc;
    begin
      inc     = {{DCO_W{1'b0}}, 1'b1} << sexp;
      dco_sub = cur - inc[DCO_W-1:0];
    end
  endfunction

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  reg [7:0] edge_bw_reg;
  reg [7:0] offs_slew_reg;
  reg [7:0] sphase_reg;
  reg [7:0] thresh_reg;

  wire wr_w;
  assign wr_w = ce_in & reg_wr_in;

  // Writes land at once and steer the loop on the next edge.
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      edge_bw_reg   <= `CDRAL_RST_EDGE_BW;
      offs_slew_reg <= `CDRAL_RST_OFFS_SLEW;
      sphase_reg    <= `CDRAL_RST_SPHASE;
      thresh_reg    <= `CDRAL_RST_THRESH;
    end else if (wr_w) begin
      case (reg_addr_in)
        `CDRAL_ADDR_EDGE_BW:   edge_bw_reg   <= reg_wdata_in;
        `CDRAL_ADDR_OFFS_SLEW: offs_slew_reg <= reg_wdata_in;
        `CDRAL_ADDR_SPHASE:    sphase_reg    <= reg_wdata_in;
        `CDRAL_ADDR_THRESH:    thresh_reg    <= reg_wdata_in;
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  // Unmapped offsets read zero. The factory offset has no write path.
  reg [7:0] rdata_next;
  always @* begin
    case (reg_addr_in)
      `CDRAL_ADDR_EDGE_BW:   rdata_next = edge_bw_reg;
      `CDRAL_ADDR_OFFS_SLEW: rdata_next = offs_slew_reg;
      `CDRAL_ADDR_SPHASE:    rdata_next = sphase_reg;
      `CDRAL_ADDR_THRESH:    rdata_next = thresh_reg;
      `CDRAL_ADDR_FACTORY:   rdata_next = {1'b0, factory_offset_in};
      default:               rdata_next = 8'h00;
    endcase
  end

  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      reg_rdata_out <= 8'h00;
    end else if (ce_in && reg_rd_in) begin
      reg_rdata_out <= rdata_next;
    end
  end

  // ----------------------------------------------------------------
  // Threshold offset decode
  // ----------------------------------------------------------------
  wire       slice_en_w;
  wire       slice_coarse_w;
  wire [6:0] slice_level_w;

  cdral_slice_map u_slice (
    .thresh_in        (thresh_reg),
    .slice_en_out     (slice_en_w),
    .slice_coarse_out (slice_coarse_w),
    .slice_level_out  (slice_level_w)
  );

  // ----------------------------------------------------------------
  // Loop settings
  // ----------------------------------------------------------------
  wire [1:0] edge_w;
  wire [1:0] slew_w;
  wire [2:0] bw_w;
  assign edge_w = edge_bw_reg[`CDRAL_EDGE_MSB:`CDRAL_EDGE_LSB];
  assign slew_w = offs_slew_reg[`CDRAL_SLEW_MSB:`CDRAL_SLEW_LSB];
  assign bw_w   = edge_bw_reg[`CDRAL_BW_MSB:`CDRAL_BW_LSB];

  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      slice_en_out                  <= 1'b1;
      slice_coarse_out              <= 1'b0;
      slice_level_out               <= 7'h00;
      adaptive_offset_en_out        <= 1'b1;
      edge_rise_only_out            <= 1'b0;
      edge_fall_only_out            <= 1'b0;
      dll_slew_out                  <= 2'h2;
      dll_track_quarter_ui_out      <= 3'h3;
      sample_phase_out              <= 4'h0;
      jitter_transfer_bandwidth_out <= 3'h4;
      loop_open_out                 <= 1'b0;
    end else if (ce_in) begin
      slice_en_out     <= slice_en_w;
      slice_coarse_out <= slice_coarse_w;
      slice_level_out  <= slice_level_w;
      // Manual offset only holds once software clears this enable.
      adaptive_offset_en_out <= offs_slew_reg[`CDRAL_ADAPT_BIT];
      edge_rise_only_out <= (edge_w == `CDRAL_EDGE_RISE);
      edge_fall_only_out <= (edge_w == `CDRAL_EDGE_FALL);
      dll_slew_out       <= slew_w;
      // Tracking amplitude expressed in quarters of a unit interval.
      dll_track_quarter_ui_out <= {1'b0, slew_w} + 3'h1;
      // Below the fast-rate range the phase shift is held at centre.
      sample_phase_out <= rate_fast_in ?
        sphase_reg[`CDRAL_SPH_MSB:`CDRAL_SPH_LSB] : 4'h0;
      jitter_transfer_bandwidth_out <= bw_w;
      // A zero field is flagged rather than fixed; the loop really opens.
      loop_open_out <= (bw_w == `CDRAL_BW_OPEN);
    end
  end

  // ----------------------------------------------------------------
  // Frequency acquisition
  // ----------------------------------------------------------------
  reg [2:0]        state_reg;
  reg [2:0]        state_next;
  reg [STEP_W-1:0] step_reg;
  reg [STEP_W-1:0] step_next;
  reg              moved_reg;
  reg              moved_next;
  reg [DCO_W-1:0]  dco_next;
  reg [DIV_W-1:0]  div_next;
  reg              lol_next;

  wire [15:0] err_w;
  wire        samp_fast_w;
  assign err_w       = abs_ppm(freq_diff_ppm_in);
  assign samp_fast_w = ~freq_diff_ppm_in[15];

  always @* begin
    state_next = state_reg;
    step_next  = step_reg;
    moved_next = moved_reg;
    dco_next   = digital_oscillator_out;
    div_next   = div_exp_out;
    lol_next   = loss_of_lock_out;
    case (state_reg)
      ST_START: begin
        dco_next   = {DCO_W{1'b0}};
        div_next   = {DIV_W{1'b0}};
        step_next  = STEP_MAX;
        moved_next = 1'b0;
        lol_next   = 1'b1;
        state_next = ST_SEARCH;
      end
      ST_SEARCH: begin
        if (freq_valid_in) begin
          if (err_w <= `CDRAL_LOCK_PPM) begin
            lol_next   = 1'b0;
            state_next = ST_TRACK;
          end else if (samp_fast_w && !moved_reg) begin
            // Still at the bottom of the octave: drop an octave.
            if (div_exp_out != DIV_MAX) begin
              div_next = div_exp_out + {{(DIV_W-1){1'b0}}, 1'b1};
            end
          end else if (samp_fast_w) begin
            // Overshoot after stepping up: back off and refine.
            dco_next = dco_sub(digital_oscillator_out, step_reg);
            if (step_reg != {STEP_W{1'b0}}) begin
              step_next = step_reg - {{(STEP_W-1){1'b0}}, 1'b1};
            end
          end else begin
            dco_next   = dco_add(digital_oscillator_out, step_reg);
            moved_next = 1'b1;
            // Close to the data rate the steps get smaller.
            if (err_w < `CDRAL_NEAR_PPM && step_reg != {STEP_W{1'b0}}) begin
              step_next = step_reg - {{(STEP_W-1){1'b0}}, 1'b1};
            end
          end
        end
      end
      ST_TRACK: begin
        if (freq_valid_in && err_w > `CDRAL_UNLOCK_PPM) begin
          lol_next   = 1'b1;
          state_next = ST_START;
        end
      end
      default: begin
        state_next = ST_START;
      end
    endcase
  end

  // The frequency loop runs only while the search is open.
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg              <= ST_START;
      step_reg               <= STEP_MAX;
      moved_reg              <= 1'b0;
      digital_oscillator_out <= {DCO_W{1'b0}};
      div_exp_out            <= {DIV_W{1'b0}};
      loss_of_lock_out       <= 1'b1;
      fll_en_out             <= 1'b1;
      pll_dll_en_out         <= 1'b0;
    end else if (ce_in) begin
      state_reg              <= state_next;
      step_reg               <= step_next;
      moved_reg              <= moved_next;
      digital_oscillator_out <= dco_next;
      div_exp_out            <= div_next;
      loss_of_lock_out       <= lol_next;
      fll_en_out             <= lol_next;
      pll_dll_en_out         <= ~lol_next;
    end
  end

endmodule // cdral_acq_ctrl

/* File: hw/cdral_regs.vh */
`ifndef CDRAL_REGS_VH
`define CDRAL_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CDRAL_ADDR_EDGE_BW      8'h10
`define CDRAL_ADDR_OFFS_SLEW    8'h13
`define CDRAL_ADDR_SPHASE       8'h14
`define CDRAL_ADDR_THRESH       8'h15
`define CDRAL_ADDR_FACTORY      8'h73

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CDRAL_RST_EDGE_BW       8'h04
`define CDRAL_RST_OFFS_SLEW     8'h12
`define CDRAL_RST_SPHASE        8'h00
`define CDRAL_RST_THRESH        8'h40

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CDRAL_BW_MSB            2
`define CDRAL_BW_LSB            0
`define CDRAL_EDGE_MSB          4
`define CDRAL_EDGE_LSB          3
`define CDRAL_SLEW_MSB          1
`define CDRAL_SLEW_LSB          0
`define CDRAL_ADAPT_BIT         4
`define CDRAL_SPH_MSB           3
`define CDRAL_SPH_LSB           0
`define CDRAL_EXT_BIT           7
`define CDRAL_SLICE_MSB         6
`define CDRAL_SLICE_LSB         0

// ----------------------------------------------------------------
// Field encodings
// ----------------------------------------------------------------
`define CDRAL_EDGE_RISE         2'h1
`define CDRAL_EDGE_FALL         2'h2
`define CDRAL_SLICE_OFF_CODE    7'h00
`define CDRAL_SLICE_MID_CODE    7'h40
`define CDRAL_BW_OPEN           3'h0

// ----------------------------------------------------------------
// Frequency windows in ppm
// ----------------------------------------------------------------
`define CDRAL_UNLOCK_PPM        16'h03E8
`define CDRAL_LOCK_PPM          16'h00FA
`define CDRAL_NEAR_PPM          16'h1F40

`endif

/* File: hw/cdral_slice_map.v */
`timescale 1ns/1ps
`include "cdral_regs.vh"

// ----------------------------------------------------------------
// Threshold offset decode
// ----------------------------------------------------------------
// Turns the threshold register into an enable, a step-size select and a
// signed level around mid code. Purely combinational; the caller registers.
module cdral_slice_map (
  input  wire [7:0] thresh_in,
  output wire       slice_en_out,
  output wire       slice_coarse_out,
  output wire [6:0] slice_level_out
);
  wire       ext_w;
  wire [6:0] code_w;

  assign ext_w  = thresh_in[`CDRAL_EXT_BIT];
  assign code_w = thresh_in[`CDRAL_SLICE_MSB:`CDRAL_SLICE_LSB];

  // Extended mode uses 1.6 mV per code instead of 0.24 mV.
  assign slice_coarse_out = ext_w;
  // Code 128 in extended mode switches the offset off.
  assign slice_en_out = ~(ext_w & (code_w == `CDRAL_SLICE_OFF_CODE));
  // 129 is the negative end, 192 zero, 255 the positive end.
  assign slice_level_out = code_w - `CDRAL_SLICE_MID_CODE;
endmodule // cdral_slice_map

/* File: verif/cdral_freq_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// Upstream rate comparator
// ----------------------------------------
// Outside a result pulse the difference bus carries a toggling pattern, so
// a design that samples it without a valid pulse picks up garbage.
module cdral_freq_model (
  input  wire         sys_clk_in,
  input  wire         go_in,
  input  wire  [15:0] diff_in,
  output logic        freq_valid_out,
  output logic [15:0] freq_diff_out
);
  initial begin
    freq_valid_out = 1'b0;
    freq_diff_out  = 16'h0000;
  end
  always @(posedge sys_clk_in) begin
    freq_valid_out <= go_in;
    freq_diff_out  <= go_in ? diff_in : ~freq_diff_out;
  end
endmodule // cdral_freq_model

/* File: verif/cdral_checker.sv */
`timescale 1ns/1ps
`include "cdral_regs.vh"
// ----------------------------------------
// Acquisition and register checks
// ----------------------------------------
module cdral_checker #(
  parameter DCO_W = 12,
  parameter DIV_W = 4
) (
  input wire               sys_clk_in,
  input wire               nrst_in,
  input wire               ce_in,
  input wire [7:0]         reg_addr_in,
  input wire [7:0]         reg_wdata_in,
  input wire               reg_wr_in,
  input wire               reg_rd_in,
  input wire [7:0]         reg_rdata_out,
  input wire [6:0]         factory_offset_in,
  input wire               freq_valid_in,
  input wire signed [15:0] freq_diff_ppm_in,
  input wire               rate_fast_in,
  input wire               loss_of_lock_out,
  input wire               fll_en_out,
  input wire               pll_dll_en_out,
  input wire [DCO_W-1:0]   digital_oscillator_out,
  input wire [DIV_W-1:0]   div_exp_out,
  input wire [1:0]         dll_slew_out,
  input wire [2:0]         dll_track_quarter_ui_out,
  input wire [3:0]         sample_phase_out,
  input wire [2:0]         jitter_transfer_bandwidth_out
);
  logic [15:0] mag;
  logic [1:0]  skip;
  logic        take, srch, far, up;
  logic [2:0]  bw_wd;
  assign mag   = freq_diff_ppm_in[15] ? -freq_diff_ppm_in : freq_diff_ppm_in;
  assign take  = ce_in && freq_valid_in && skip == 2'h0;
  assign srch  = take && loss_of_lock_out;
  assign far   = mag > `CDRAL_LOCK_PPM;
  assign bw_wd = reg_wdata_in[2:0];
  // Results right after reset or unlock are ignored by the design, so skip them.
  always @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      skip <= 2'h2;
      up   <= 1'b0;
    end else if (ce_in) begin
      skip <= (take && !loss_of_lock_out && mag > `CDRAL_UNLOCK_PPM) ? 2'h3
              : skip - {1'b0, |skip};
      up   <= (skip != 2'h0) ? 1'b0 : (up | (srch && far && freq_diff_ppm_in[15]));
    end
  end
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!nrst_in);
  sequence s_unlock;
    take && !loss_of_lock_out && mag > `CDRAL_UNLOCK_PPM;
  endsequence
  sequence s_restart;
    loss_of_lock_out ##1 (digital_oscillator_out == '0 && div_exp_out == '0);
  endsequence
  sequence s_bw_wr;
    ce_in && reg_wr_in && reg_addr_in == `CDRAL_ADDR_EDGE_BW ##1 ce_in;
  endsequence
  property p_unlock; s_unlock |=> loss_of_lock_out; endproperty
  property p_restart; s_unlock |=> s_restart; endproperty
  property p_double;
    srch && far && !freq_diff_ppm_in[15] && !up && !(&div_exp_out)
      |=> div_exp_out == $past(div_exp_out) + 1'b1;
  endproperty
  property p_raise;
    srch && far && freq_diff_ppm_in[15]
      |=> digital_oscillator_out > $past(digital_oscillator_out) || &digital_oscillator_out;
  endproperty
  property p_lock; srch && !far |=> !loss_of_lock_out; endproperty
  property p_hold; !(ce_in && freq_valid_in) |=> $stable(loss_of_lock_out); endproperty
  property p_handover;
    fll_en_out == loss_of_lock_out && pll_dll_en_out != loss_of_lock_out;
  endproperty
  property p_track; dll_track_quarter_ui_out == dll_slew_out + 3'h1; endproperty
  property p_phase;
    !rate_fast_in && ce_in ##1 !rate_fast_in |-> sample_phase_out == 4'h0;
  endproperty
  property p_bw; s_bw_wr |=> jitter_transfer_bandwidth_out == $past(bw_wd, 2); endproperty
  property p_factory;
    ce_in && reg_rd_in && reg_addr_in == `CDRAL_ADDR_FACTORY
      |=> reg_rdata_out == {1'b0, $past(factory_offset_in)};
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock not flagged");
  a_restart: assert property (p_restart) else $error("no restart");
  a_double: assert property (p_double) else $error("ratio not doubled");
  a_raise: assert property (p_raise) else $error("oscillator not raised");
  a_lock: assert property (p_lock) else $error("lock not declared");
  a_hold: assert property (p_hold) else $error("lock flag moved alone");
  a_handover: assert property (p_handover) else $error("loop handover wrong");
  a_track: assert property (p_track) else $error("tracking span wrong");
  a_phase: assert property (p_phase) else $error("phase not gated");
  a_bw: assert property (p_bw) else $error("bandwidth not applied");
  a_factory: assert property (p_factory) else $error("factory read wrong");
endmodule // cdral_checker

bind cdral_acq_ctrl cdral_checker #(.DCO_W(DCO_W), .DIV_W(DIV_W)) i_chk (
  .sys_clk_in, .nrst_in, .ce_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
  .reg_rdata_out, .factory_offset_in, .freq_valid_in, .freq_diff_ppm_in, .rate_fast_in,
  .loss_of_lock_out, .fll_en_out, .pll_dll_en_out, .digital_oscillator_out, .div_exp_out,
  .dll_slew_out, .dll_track_quarter_ui_out, .sample_phase_out, .jitter_transfer_bandwidth_out);

/* File: verif/cdr_acquisition_loop_control_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin \
  tests_run++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); \
  end \
end

module cdr_acquisition_loop_control_bench;
  typedef struct {logic w; logic [7:0] a, d, r; logic [15:0] e, m;} cdral_row_t;
  logic        sys_clk_in, nrst_in, ce_in, reg_wr_in, reg_rd_in, go, rate_fast_in;
  logic        freq_valid_in, loss_of_lock_out, fll_en_out, pll_dll_en_out, loop_open_out;
  logic        slice_en_out, slice_coarse_out, adaptive_offset_en_out;
  logic        edge_rise_only_out, edge_fall_only_out;
  logic [7:0]  reg_addr_in, reg_wdata_in, reg_rdata_out;
  logic [6:0]  factory_offset_in, slice_level_out;
  logic [15:0] freq_diff_ppm_in, go_diff;
  logic [11:0] digital_oscillator_out;
  logic [3:0]  div_exp_out, sample_phase_out;
  logic [1:0]  dll_slew_out;
  logic [2:0]  dll_track_quarter_ui_out, jitter_transfer_bandwidth_out;
  int          bad_count, tests_run;
  cdral_row_t  rows [19] = '{
    '{0, 8'h10, 8'h00, 8'h04, 16'h0004, 16'h001F},
    '{0, 8'h13, 8'h00, 8'h12, 16'h0033, 16'h003F},
    '{0, 8'h14, 8'h00, 8'h00, 16'h0000, 16'h000F},
    '{0, 8'h15, 8'h00, 8'h40, 16'h0100, 16'h01FF},
    '{1, 8'h10, 8'h0A, 8'h0A, 16'h0012, 16'h001F},
    '{1, 8'h10, 8'h17, 8'h17, 16'h000F, 16'h001F},
    '{1, 8'h10, 8'h1C, 8'h1C, 16'h0004, 16'h001F},
    '{1, 8'h13, 8'h00, 8'h00, 16'h0001, 16'h003F},
    '{1, 8'h13, 8'h03, 8'h03, 16'h001C, 16'h003F},
    '{1, 8'h14, 8'h09, 8'h09, 16'h0009, 16'h000F},
    '{1, 8'h14, 8'h08, 8'h08, 16'h0008, 16'h000F},
    '{1, 8'h15, 8'h45, 8'h45, 16'h0105, 16'h01FF},
    '{1, 8'h15, 8'h00, 8'h00, 16'h0140, 16'h01FF},
    '{1, 8'h15, 8'hC0, 8'hC0, 16'h0180, 16'h01FF},
    '{1, 8'h15, 8'h81, 8'h81, 16'h01C1, 16'h01FF},
    '{1, 8'h15, 8'hFF, 8'hFF, 16'h01BF, 16'h01FF},
    '{1, 8'h15, 8'h80, 8'h80, 16'h0000, 16'h0100},
    '{1, 8'h73, 8'h55, 8'h2A, 16'h0000, 16'h0000},
    '{1, 8'h20, 8'h33, 8'h00, 16'h0000, 16'h0000}};

  cdral_acq_ctrl i_dut (.sys_clk_in, .nrst_in, .ce_in, .reg_addr_in, .reg_wdata_in,
    .reg_wr_in, .reg_rd_in, .reg_rdata_out, .factory_offset_in, .freq_valid_in,
    .freq_diff_ppm_in, .rate_fast_in, .loss_of_lock_out, .fll_en_out, .pll_dll_en_out,
    .digital_oscillator_out, .div_exp_out, .slice_en_out, .slice_coarse_out,
    .slice_level_out, .adaptive_offset_en_out, .edge_rise_only_out, .edge_fall_only_out,
    .dll_slew_out, .dll_track_quarter_ui_out, .sample_phase_out,
    .jitter_transfer_bandwidth_out, .loop_open_out);
  cdral_freq_model i_freq (.sys_clk_in, .go_in(go), .diff_in(go_diff),
    .freq_valid_out(freq_valid_in), .freq_diff_out(freq_diff_ppm_in));

  function automatic logic [15:0] sig(input logic [7:0] a);
    case (a)
      8'h10: sig = 16'({edge_rise_only_out, edge_fall_only_out, jitter_transfer_bandwidth_out});
      8'h13: sig = 16'({adaptive_offset_en_out, dll_slew_out, dll_track_quarter_ui_out});
      8'h14: sig = 16'(sample_phase_out);
      8'h15: sig = 16'({slice_en_out, slice_coarse_out, slice_level_out});
      default: sig = 16'h0000;
    endcase
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, d);
    @(posedge sys_clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_wr_in <= w;
    reg_rd_in <= !w;
    @(posedge sys_clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
  endtask
  // Result reaches the design two edges after the request; one more edge covers restart.
  task automatic send(input logic [15:0] d);
    @(posedge sys_clk_in);
    go <= 1'b1;
    go_diff <= d;
    @(posedge sys_clk_in);
    go <= 1'b0;
    tick(2);
  endtask
  task automatic summarize();
    if (bad_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    sys_clk_in = 1'b0;
    forever #5 sys_clk_in = ~sys_clk_in;
  end
  initial begin
    repeat (5000) @(posedge sys_clk_in);
    bad_count++;
    summarize();
  end
  initial begin
    {nrst_in, reg_wr_in, reg_rd_in, go, reg_addr_in, reg_wdata_in, go_diff} = '0;
    ce_in = 1'b1;
    rate_fast_in = 1'b1;
    factory_offset_in = 7'h2A;
    tick(6);
    `CHK({loss_of_lock_out, fll_en_out, pll_dll_en_out}, 3'h6)
    `CHK({dll_slew_out, dll_track_quarter_ui_out, jitter_transfer_bandwidth_out}, 8'h9C)
    nrst_in <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i].w)
        bus(1'b1, rows[i].a, rows[i].d);
      bus(1'b0, rows[i].a, 8'h00);
      tick(2);
      `CHK(reg_rdata_out, rows[i].r)
      `CHK(sig(rows[i].a) & rows[i].m, rows[i].e)
    end
    // The bench never writes a zero bandwidth field, so the loop stays closed.
    `CHK(loop_open_out, 1'b0)
    rate_fast_in <= 1'b0;
    tick(3);
    `CHK(sample_phase_out, 4'h0)
    rate_fast_in <= 1'b1;
    tick(3);
    `CHK(sample_phase_out, 4'h8)
    send(16'h1388);
    `CHK({div_exp_out, digital_oscillator_out}, 16'h1000)
    send(16'hB1E0);
    `CHK({div_exp_out, digital_oscillator_out}, 16'h1FFF)
    send(16'h00C8);
    `CHK({loss_of_lock_out, fll_en_out, pll_dll_en_out}, 3'h1)
    send(16'h03E8);
    `CHK(loss_of_lock_out, 1'b0)
    send(16'hFC17);
    `CHK({loss_of_lock_out, digital_oscillator_out, div_exp_out}, 17'h10000)
    nrst_in <= 1'b0;
    tick(2);
    nrst_in <= 1'b1;
    bus(1'b0, 8'h15, 8'h00);
    tick(2);
    `CHK(reg_rdata_out, 8'h40)
    summarize();
  end
endmodule // cdr_acquisition_loop_control_bench
